// [bench/radio_misc_control_and_channel_regs_test.sv]
/*
 * Self-checking bench of the misc control and rf channel registers.
 * Assumes the host model drives requests; reads are checked from a queue.
 */
`default_nettype none
module radio_misc_control_and_channel_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, sys_rst, amp_tx_active, rhit_q, id_rd_q, id_en_q, pin_q, pin_oe_q, soft_q;
    rmc_pkg::rmc_req_t req;
    rmc_pkg::rmc_fwd_t fwd_q;
    logic [7:0] rdata_q;
    logic [5:0] id_addr_q;
    logic [6:0] chan_q;
    logic [6:0] ch;
    logic [11:0] freq_q;
    logic [7:0] exp_q[$];
    logic [7:0] amp_cfg [3] = '{8'h04, 8'h06, 8'h02};
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;

    rmc_host i_rmc_host (.clock(clock), .req(req));
    rmc_regs i_rmc_regs (.clock(clock), .sys_rst(sys_rst), .req(req),
        .amp_tx_active(amp_tx_active), .rdata_q(rdata_q), .rhit_q(rhit_q),
        .prot_fwd_q(fwd_q), .id_rd_q(id_rd_q), .id_addr_q(id_addr_q),
        .id_read_enable_q(id_en_q), .external_amp_control_pin_q(pin_q),
        .external_amp_control_pin_oe_q(pin_oe_q), .rf_channel_select_q(chan_q),
        .synth_freq_mhz_q(freq_q), .device_soft_reset_q(soft_q));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_rmc_host.xfer(1'b0, a, 8'h00);
    endtask

    // read results come off the queue
    always @(negedge clock) begin
        if (rhit_q === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected read", 16'h0001, 16'h0000);
            else check("rdata", 16'(rdata_q), 16'(exp_q.pop_front()));
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        sys_rst = 1'b1;
        amp_tx_active = 1'b0;
        void'($urandom(32'hEC778040));
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        check("freq reset", 16'(freq_q), 16'h0960);
        rd(6'h20, 8'h00);
        rd(6'h21, 8'h00);
        for (int i = 0; i < 8; i++) begin
            ch = (i == 0) ? 7'h02 : (i == 1) ? 7'h4F : 7'($urandom_range(79, 2));
            i_rmc_host.write(6'h21, {1'b0, ch});
            check("chan", 16'(chan_q), 16'(ch));
            check("freq", 16'(freq_q), 16'(12'h960 + 12'(ch)));
            rd(6'h21, {1'b0, ch});
        end
        i_rmc_host.write(6'h2E, 8'hA5);
        check("locked fwd", 16'(fwd_q.wr), 16'h0000);
        i_rmc_host.write(6'h20, 8'h40);
        i_rmc_host.write(6'h2F, 8'h3C);
        check("fwd", 16'(fwd_q), 16'({1'b1, 6'h2F, 8'h3C}));
        rd(6'h20, 8'h40);
        i_rmc_host.xfer(1'b0, 6'h3C, 8'h00);
        check("id locked", 16'(id_rd_q), 16'h0000);
        i_rmc_host.write(6'h20, 8'h60);
        check("id enable", 16'(id_en_q), 16'h0001);
        i_rmc_host.xfer(1'b0, 6'h3F, 8'h00);
        check("id read", 16'({id_rd_q, id_addr_q}), 16'h007F);
        i_rmc_host.write(6'h20, 8'h40);
        // enable, then polarity, then disable: one field per write
        foreach (amp_cfg[k]) begin
            i_rmc_host.write(6'h20, amp_cfg[k]);
            repeat (2) @(negedge clock);
            check("amp oe", 16'(pin_oe_q), 16'(amp_cfg[k][2]));
            repeat (6) begin
                amp_tx_active = 1'($urandom);
                @(negedge clock);
                if (amp_cfg[k][2]) begin
                    check("amp pin", 16'(pin_q), 16'(amp_tx_active ^ amp_cfg[k][1]));
                end
            end
        end
        rd(6'h20, 8'h02);
        i_rmc_host.write(6'h21, 8'h10);
        i_rmc_host.write(6'h20, 8'h61);
        check("soft pulse", 16'(soft_q), 16'h0001);
        check("chan dflt", 16'(chan_q), 16'h0000);
        check("freq dflt", 16'(freq_q), 16'h0960);
        @(negedge clock);
        check("soft clear", 16'(soft_q), 16'h0000);
        rd(6'h20, 8'h00);
        rd(6'h21, 8'h00);
        repeat (2) @(negedge clock);
        check("queue empty", 16'(exp_q.size()), 16'h0000);
        results();
    end
endmodule
`default_nettype wire

// [bench/rmc_host.sv]
/*
 * Host microcontroller model: issues register requests to the misc/channel bank.
 * Assumes the bench clock; requests launch on the falling edge, one cycle long.
 */
`default_nettype none
module rmc_host (
    input wire logic clock,
    output var rmc_pkg::rmc_req_t req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clock);
        req = '0;
    endtask
    task automatic write(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == rmc_pkg::OFF_MISC_CONTROL) ? 8'h67
            : (a == rmc_pkg::OFF_RF_CHANNEL) ? 8'h7F : 8'hFF;
        xfer(1'b1, a, d & m);
    endtask
endmodule
`default_nettype wire

// [rtl/rmc_pkg.sv]
/*
 * Package for the radio misc control and channel register bank:
 * offsets, field positions, reset values and the request carrier.
 * Assumes a 6-bit register address space driven by the serial port engine.
 */
`default_nettype none
package rmc_pkg;
    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int CHAN_W = 7;
    localparam int FREQ_W = 12;
    localparam logic [ADDR_W-1:0] OFF_MISC_CONTROL = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_RF_CHANNEL = 6'h21;
    localparam logic [ADDR_W-1:0] OFF_PROT_LO = 6'h2E;
    localparam logic [ADDR_W-1:0] OFF_PROT_HI = 6'h2F;
    localparam logic [ADDR_W-1:0] OFF_ID_LO = 6'h3C;
    localparam logic [ADDR_W-1:0] OFF_ID_HI = 6'h3F;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_UNLOCK = 6;
    localparam int BIT_ID_READ = 5;
    localparam int BIT_AMP_OE = 2;
    localparam int BIT_AMP_POL = 1;
    localparam int BIT_SOFT_RST = 0;
    localparam logic [DATA_W-1:0] RST_MISC_CONTROL = 8'h00;
    localparam logic [CHAN_W-1:0] RST_RF_CHANNEL = 7'h00;
    localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

    // synthesizer frequency in MHz is base plus channel code
    localparam logic [FREQ_W-1:0] FREQ_BASE_MHZ = 12'h960;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rmc_req_t;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rmc_fwd_t;
endpackage
`default_nettype wire

// [rtl/rmc_regs.sv]
/*
 * Misc control and rf channel registers of the radio modem, with the
 * write gate for the two protected registers, the read gate for the
 * identity registers, the external amplifier control pin and the soft reset.
 * Assumes the serial port engine presents one-cycle read/write requests on
 * the same clock and takes read data one cycle after a read request.
 */
`default_nettype none
// Behaviour
// - unlock bit 6 allows protected register writes
// - bit 5 gates identity register reads
// - bit 2 enables amplifier pin drive
// - bit 1 set makes pin active low
// - bit 0 write resets all, self-clears
// - channel bits 6:0 set synthesizer frequency
// - adjacent channel codes one MHz apart
module rmc_regs (
    input wire logic clock,
    input wire logic sys_rst,
    input wire rmc_pkg::rmc_req_t req,
    input wire logic amp_tx_active,
    output logic [rmc_pkg::DATA_W-1:0] rdata_q,
    output logic rhit_q,
    output rmc_pkg::rmc_fwd_t prot_fwd_q,
    output logic id_rd_q,
    output logic [rmc_pkg::ADDR_W-1:0] id_addr_q,
    output logic id_read_enable_q,
    output logic external_amp_control_pin_q,
    output logic external_amp_control_pin_oe_q,
    output logic [rmc_pkg::CHAN_W-1:0] rf_channel_select_q,
    output logic [rmc_pkg::FREQ_W-1:0] synth_freq_mhz_q,
    output logic device_soft_reset_q
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic wr_misc;
    logic wr_chan;
    logic hit_prot;
    logic hit_id;
    logic soft_rst_req;
    logic unlock_q;
    logic amp_oe_q;
    logic amp_pol_q;

    assign wr_misc = req.wr && (req.addr == rmc_pkg::OFF_MISC_CONTROL);
    assign wr_chan = req.wr && (req.addr == rmc_pkg::OFF_RF_CHANNEL);
    assign hit_prot = (req.addr == rmc_pkg::OFF_PROT_LO) || (req.addr == rmc_pkg::OFF_PROT_HI);
    assign hit_id = (req.addr >= rmc_pkg::OFF_ID_LO) && (req.addr <= rmc_pkg::OFF_ID_HI);
    assign soft_rst_req = wr_misc && req.wdata[rmc_pkg::BIT_SOFT_RST];

    // ------------------------------------------------------------
    // misc control
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            unlock_q <= rmc_pkg::RST_MISC_CONTROL[rmc_pkg::BIT_UNLOCK];
            id_read_enable_q <= rmc_pkg::RST_MISC_CONTROL[rmc_pkg::BIT_ID_READ];
            amp_oe_q <= rmc_pkg::RST_MISC_CONTROL[rmc_pkg::BIT_AMP_OE];
            amp_pol_q <= rmc_pkg::RST_MISC_CONTROL[rmc_pkg::BIT_AMP_POL];
        end else if (soft_rst_req) begin
            // every field back to default
            unlock_q <= rmc_pkg::RST_MISC_CONTROL[rmc_pkg::BIT_UNLOCK];
            id_read_enable_q <= rmc_pkg::RST_MISC_CONTROL[rmc_pkg::BIT_ID_READ];
            amp_oe_q <= rmc_pkg::RST_MISC_CONTROL[rmc_pkg::BIT_AMP_OE];
            amp_pol_q <= rmc_pkg::RST_MISC_CONTROL[rmc_pkg::BIT_AMP_POL];
        end else if (wr_misc) begin
            unlock_q <= req.wdata[rmc_pkg::BIT_UNLOCK];
            id_read_enable_q <= req.wdata[rmc_pkg::BIT_ID_READ];
            amp_oe_q <= req.wdata[rmc_pkg::BIT_AMP_OE];
            amp_pol_q <= req.wdata[rmc_pkg::BIT_AMP_POL];
        end
    end

    // one-cycle reset pulse to the rest of the device
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            device_soft_reset_q <= 1'b0;
        end else begin
            device_soft_reset_q <= soft_rst_req;
        end
    end

    // ------------------------------------------------------------
    // channel and synthesizer frequency
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rf_channel_select_q <= rmc_pkg::RST_RF_CHANNEL;
            synth_freq_mhz_q <= rmc_pkg::FREQ_BASE_MHZ;
        end else if (soft_rst_req) begin
            rf_channel_select_q <= rmc_pkg::RST_RF_CHANNEL;
            synth_freq_mhz_q <= rmc_pkg::FREQ_BASE_MHZ;
        end else if (wr_chan) begin
            rf_channel_select_q <= req.wdata[rmc_pkg::CHAN_W-1:0];
            // one MHz per code step
            synth_freq_mhz_q <= rmc_pkg::FREQ_BASE_MHZ
                + {{(rmc_pkg::FREQ_W-rmc_pkg::CHAN_W){1'b0}}, req.wdata[rmc_pkg::CHAN_W-1:0]};
        end
    end

    // ------------------------------------------------------------
    // protected register write gate
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prot_fwd_q <= '0;
        end else begin
            // locked writes vanish without error
            prot_fwd_q.wr <= req.wr && hit_prot && unlock_q;
            prot_fwd_q.addr <= req.addr;
            prot_fwd_q.wdata <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // identity register read gate
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            id_rd_q <= 1'b0;
            id_addr_q <= '0;
        end else begin
            id_rd_q <= req.rd && hit_id && id_read_enable_q;
            id_addr_q <= req.addr;
        end
    end

    // ------------------------------------------------------------
    // read data of this bank
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= rmc_pkg::RDATA_UNMAPPED;
            rhit_q <= 1'b0;
        end else if (req.rd && req.addr == rmc_pkg::OFF_MISC_CONTROL) begin
            // reset bit always reads zero
            rdata_q <= {1'b0, unlock_q, id_read_enable_q, 2'b00, amp_oe_q, amp_pol_q, 1'b0};
            rhit_q <= 1'b1;
        end else if (req.rd && req.addr == rmc_pkg::OFF_RF_CHANNEL) begin
            rdata_q <= {1'b0, rf_channel_select_q};
            rhit_q <= 1'b1;
        end else begin
            rdata_q <= rmc_pkg::RDATA_UNMAPPED;
            rhit_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // external amplifier control pin
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            external_amp_control_pin_q <= 1'b0;
            external_amp_control_pin_oe_q <= 1'b0;
        end else begin
            external_amp_control_pin_oe_q <= amp_oe_q;
            external_amp_control_pin_q <= amp_tx_active ^ amp_pol_q;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_locked_prot_write;
        req.wr && hit_prot && !unlock_q;
    endsequence

    sequence s_soft_reset_write;
        soft_rst_req;
    endsequence

    property p_prot_unlocked;
        @(posedge clock) disable iff (sys_rst)
        (req.wr && hit_prot && unlock_q) |=> prot_fwd_q.wr && prot_fwd_q.addr == $past(req.addr);
    endproperty
    a_prot_unlocked: assert property (p_prot_unlocked)
        else $error("unlocked write lost");

    property p_prot_locked;
        @(posedge clock) disable iff (sys_rst)
        s_locked_prot_write |=> !prot_fwd_q.wr;
    endproperty
    a_prot_locked: assert property (p_prot_locked) else $error("locked write passed");

    property p_id_gate;
        @(posedge clock) disable iff (sys_rst)
        id_rd_q |-> $past(id_read_enable_q) && $past(req.rd) && $past(hit_id);
    endproperty
    a_id_gate: assert property (p_id_gate) else $error("identity read not gated");

    property p_amp_oe;
        @(posedge clock) disable iff (sys_rst)
        (wr_misc && !soft_rst_req) |=> ##1 external_amp_control_pin_oe_q
            == $past(req.wdata[rmc_pkg::BIT_AMP_OE], 2);
    endproperty
    a_amp_oe: assert property (p_amp_oe) else $error("pin enable wrong");

    property p_amp_level;
        @(posedge clock) disable iff (sys_rst)
        external_amp_control_pin_oe_q |-> external_amp_control_pin_q
            == ($past(amp_tx_active) ^ $past(amp_pol_q));
    endproperty
    a_amp_level: assert property (p_amp_level) else $error("pin level wrong");

    property p_soft_reset;
        @(posedge clock) disable iff (sys_rst)
        s_soft_reset_write |=> device_soft_reset_q
            && rf_channel_select_q == rmc_pkg::RST_RF_CHANNEL
            && !unlock_q && !amp_oe_q ##1 !device_soft_reset_q || soft_rst_req;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

    property p_channel;
        @(posedge clock) disable iff (sys_rst)
        (wr_chan && !soft_rst_req) |=> rf_channel_select_q
            == $past(req.wdata[rmc_pkg::CHAN_W-1:0]);
    endproperty
    a_channel: assert property (p_channel) else $error("channel not stored");

    property p_freq;
        @(posedge clock) disable iff (sys_rst)
        synth_freq_mhz_q == rmc_pkg::FREQ_BASE_MHZ
            + {{(rmc_pkg::FREQ_W-rmc_pkg::CHAN_W){1'b0}}, rf_channel_select_q};
    endproperty
    a_freq: assert property (p_freq) else $error("frequency step wrong");
endmodule
`default_nettype wire
